// >>> pkg/mmt_pkg.sv
// package: register map, field layout and mode codes of the multimode timer
package mmt_pkg;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned PRESC_W = 8;
	localparam int unsigned STAT_W = 2;
	localparam int unsigned CTRL_W = 10;

	localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_CLEAR = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = 5'h14;
	localparam logic [ADDR_W-1:0] ADDR_PRESCALE = 5'h18;

	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CTRL_MODE_MSB = 5;
	localparam int unsigned CTRL_UP = 6;
	localparam int unsigned CTRL_FREE = 7;
	localparam int unsigned CTRL_MEAS_WIDTH = 8;
	localparam int unsigned CTRL_EDGE_FALL = 9;

	localparam int unsigned STAT_REQ = 0;
	localparam int unsigned STAT_CAP = 1;

	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h002;
	localparam logic [CNT_W-1:0] CNT_ONES = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] PWM_PERIOD = 16'hFFFF;
	localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;
	localparam logic [STAT_W-1:0] STAT_ZERO = 2'h0;

	typedef enum logic [4:0] {
		MMT_TIMER = 5'h01,
		MMT_EVENT = 5'h02,
		MMT_ONESHOT = 5'h04,
		MMT_PWM = 5'h08,
		MMT_MEAS = 5'h10
	} mmt_mode_t;
endpackage

// >>> hw/mmt_prescale.sv
// count-source divider: one tick every div+1 clocks
`timescale 1ns/1ns
module mmt_prescale #(
	parameter int unsigned W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] div,
	output logic tick
);
	logic [W-1:0] cnt;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt >= div) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// >>> hw/mmt_edge.sv
// edge detector for the timer input pin; input is already synchronous
`timescale 1ns/1ns
module mmt_edge (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic prev;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev <= 1'b0;
		end else begin
			prev <= pin;
		end
	end

	assign rise = pin & ~prev;
	assign fall = ~pin & prev;
endmodule

// >>> hw/mmt_timer.sv
// multimode timer: timer, event counter, one-shot, pwm and pulse measurement
// Function
// - timer read live; reload instant reads all ones
// - event read at reload: ones under, zeros over
// - halted write then read returns written value
// - one-shot abort stops and reloads counter
// - one-shot abort drives output pin low
// - one-shot abort raises interrupt request
// - entering one-shot from timer/event sets request
// - entering pwm from timer/event sets request
// - pwm stop while high: low, request
// - pwm stop while low: stays low, no request
// - measurement select change while counting sets request
// - first measurement edge captures, no request
`timescale 1ns/1ns
module mmt_timer #(
	parameter int unsigned DATA_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [mmt_pkg::ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	output logic irq,
	output logic first_timer_output_pin,
	input wire logic auxiliary_timer_io_pin_in,
	output logic auxiliary_timer_io_pin_out,
	output logic auxiliary_timer_io_pin_oe
);
	import mmt_pkg::*;

	if (DATA_W < CNT_W) begin : g_chk
		$error("mmt_timer: DATA_W must hold the counter");
	end
	if (CTRL_W > DATA_W) begin : g_chk_ctrl
		$error("mmt_timer: control word wider than the data bus");
	end
	if (PRESC_W > DATA_W) begin : g_chk_presc
		$error("mmt_timer: prescaler wider than the data bus");
	end
	// the mode field is decoded straight into the one-hot mode codes
	if (CTRL_MODE_MSB - CTRL_MODE_LSB + 1 != $bits(mmt_mode_t)) begin : g_chk_mode
		$error("mmt_timer: mode field does not match the mode codes");
	end
	if (STAT_W != STAT_CAP + 1) begin : g_chk_stat
		$error("mmt_timer: status width must hold request and capture only");
	end

	logic [CTRL_W-1:0] ctrl;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] reload;
	logic [PRESC_W-1:0] prescale;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] enable;
	logic out_q;
	logic active;
	logic first_seen;
	logic tick;
	logic pin_rise;
	logic pin_fall;
	logic meas_edge;
	logic ev_edge;
	logic start;
	logic wr_ctrl;
	logic start_rise;
	logic start_fall;
	mmt_mode_t mode;
	logic [CTRL_MODE_MSB-CTRL_MODE_LSB:0] new_mode;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] next_reload;
	logic next_out;
	logic next_active;
	logic next_first;
	logic req_evt;
	logic cap_evt;
	logic reload_hit;
	logic reload_over;
	logic [STAT_W-1:0] next_status;
	logic [STAT_W-1:0] clr;

	mmt_prescale #(
		.W(PRESC_W)
	) u_presc (
		.clk(clk),
		.rst_b(rst_b),
		.div(prescale),
		.tick(tick)
	);

	mmt_edge u_edge (
		.clk(clk),
		.rst_b(rst_b),
		.pin(auxiliary_timer_io_pin_in),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign start = ctrl[CTRL_START];
	assign wr_ctrl = wr && (addr == ADDR_CTRL);
	assign start_rise = wr_ctrl && !start && wdata[CTRL_START];
	assign start_fall = wr_ctrl && start && !wdata[CTRL_START];
	assign new_mode = wdata[CTRL_MODE_MSB:CTRL_MODE_LSB];
	assign ev_edge = ctrl[CTRL_EDGE_FALL] ? pin_fall : pin_rise;
	// width measurement needs both edges, period only the selected one
	assign meas_edge = ctrl[CTRL_MEAS_WIDTH] ? (pin_rise | pin_fall) : ev_edge;
	assign clr = (wr && (addr == ADDR_CLEAR)) ? wdata[STAT_W-1:0] : STAT_ZERO;

	always_comb begin
		unique case (ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB])
			MMT_TIMER: mode = MMT_TIMER;
			MMT_EVENT: mode = MMT_EVENT;
			MMT_ONESHOT: mode = MMT_ONESHOT;
			MMT_PWM: mode = MMT_PWM;
			MMT_MEAS: mode = MMT_MEAS;
			// software may write a non one-hot code; it runs as timer mode
			default: mode = MMT_TIMER;
		endcase
	end

	always_comb begin
		next_cnt = cnt;
		next_reload = reload;
		next_out = out_q;
		next_active = active;
		next_first = first_seen;
		req_evt = 1'b0;
		cap_evt = 1'b0;
		reload_hit = 1'b0;
		reload_over = 1'b0;
		if (wr && (addr == ADDR_COUNT)) begin
			next_reload = wdata[CNT_W-1:0];
			if (!start) begin
				next_cnt = wdata[CNT_W-1:0];
			end
		end
		unique case (mode)
			MMT_TIMER: begin
				if (start && tick) begin
					if (cnt == CNT_ZERO) begin
						next_cnt = reload;
						req_evt = 1'b1;
						reload_hit = 1'b1;
					end else begin
						next_cnt = cnt - CNT_ONE;
					end
				end
			end
			MMT_EVENT: begin
				if (start && ev_edge) begin
					if (ctrl[CTRL_UP]) begin
						if (cnt == CNT_ONES) begin
							// free run just wraps; the value is stale once stopped
							next_cnt = ctrl[CTRL_FREE] ? CNT_ZERO : reload;
							req_evt = 1'b1;
							reload_hit = 1'b1;
							reload_over = 1'b1;
						end else begin
							next_cnt = cnt + CNT_ONE;
						end
					end else if (cnt == CNT_ZERO) begin
						next_cnt = ctrl[CTRL_FREE] ? CNT_ONES : reload;
						req_evt = 1'b1;
						reload_hit = 1'b1;
					end else begin
						next_cnt = cnt - CNT_ONE;
					end
				end
			end
			MMT_ONESHOT: begin
				if (start_rise) begin
					next_active = 1'b1;
					next_out = 1'b1;
					next_cnt = reload;
				end else if (start_fall && active) begin
					next_active = 1'b0;
					next_cnt = reload;
					next_out = 1'b0;
					req_evt = 1'b1;
				end else if (active && tick) begin
					if (cnt == CNT_ZERO) begin
						next_active = 1'b0;
						next_out = 1'b0;
						next_cnt = reload;
						req_evt = 1'b1;
					end else begin
						next_cnt = cnt - CNT_ONE;
					end
				end
			end
			MMT_PWM: begin
				if (start_rise) begin
					next_active = 1'b1;
					next_out = 1'b1;
					next_cnt = reload;
				end else if (start_fall && active) begin
					next_active = 1'b0;
					next_cnt = reload;
					if (out_q) begin
						next_out = 1'b0;
						req_evt = 1'b1;
					end // low output stays low, no request
				end else if (active && tick) begin
					if (cnt != CNT_ZERO) begin
						next_cnt = cnt - CNT_ONE;
					end else if (out_q) begin
						next_out = 1'b0;
						next_cnt = PWM_PERIOD - reload;
						req_evt = 1'b1;
					end else begin
						next_out = 1'b1;
						next_cnt = reload;
					end
				end
			end
			MMT_MEAS: begin
				if (start_rise) begin
					next_cnt = CNT_ZERO;
					next_first = 1'b0;
				end else if (start && meas_edge) begin
					// first capture holds a partial count, meaningless to software
					next_reload = cnt;
					next_cnt = CNT_ZERO;
					next_first = 1'b1;
					if (first_seen) begin
						cap_evt = 1'b1;
						req_evt = 1'b1;
					end
				end else if (start && tick) begin
					next_cnt = cnt + CNT_ONE;
					if (cnt == CNT_ONES) begin
						req_evt = 1'b1;
					end
				end
				if (wr_ctrl && start && (wdata[CTRL_MEAS_WIDTH] != ctrl[CTRL_MEAS_WIDTH])) begin
					req_evt = 1'b1;
				end
			end
		endcase
		// leaving one-shot or pwm mid-count would strand a high output with its enable gone
		if (mode != MMT_ONESHOT && mode != MMT_PWM) begin
			next_out = 1'b0;
			next_active = 1'b0;
		end
		// reset mode is timer, so the first selection after reset is covered too
		if (wr_ctrl && (mode == MMT_TIMER || mode == MMT_EVENT)) begin
			if (new_mode == MMT_ONESHOT) begin
				req_evt = 1'b1;
			end
			if (new_mode == MMT_PWM) begin
				req_evt = 1'b1;
			end
		end
	end

	// set wins over a clear in the same cycle
	assign next_status = (status & ~clr) | {cap_evt, req_evt};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= CTRL_RST;
			prescale <= PRESC_RST;
			enable <= STAT_ZERO;
		end else if (wr) begin
			if (addr == ADDR_CTRL) begin
				ctrl <= wdata[CTRL_W-1:0];
			end
			if (addr == ADDR_PRESCALE) begin
				prescale <= wdata[PRESC_W-1:0];
			end
			if (addr == ADDR_ENABLE) begin
				enable <= wdata[STAT_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= CNT_ZERO;
			reload <= CNT_ZERO;
			out_q <= 1'b0;
			active <= 1'b0;
			first_seen <= 1'b0;
		end else begin
			cnt <= next_cnt;
			reload <= next_reload;
			out_q <= next_out;
			active <= next_active;
			first_seen <= next_first;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status <= STAT_ZERO;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(next_status & enable);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			first_timer_output_pin <= 1'b0;
			auxiliary_timer_io_pin_out <= 1'b0;
			auxiliary_timer_io_pin_oe <= 1'b0;
		end else begin
			first_timer_output_pin <= next_out;
			auxiliary_timer_io_pin_out <= next_out;
			auxiliary_timer_io_pin_oe <= (mode == MMT_ONESHOT) || (mode == MMT_PWM);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= '0;
		end else if (rd) begin
			unique case (addr)
				ADDR_CTRL: rdata <= DATA_W'(ctrl);
				ADDR_COUNT: begin
					if (reload_hit) begin
						rdata <= DATA_W'(reload_over ? CNT_ZERO : CNT_ONES);
					end else begin
						rdata <= DATA_W'(cnt);
					end
				end
				ADDR_RELOAD: rdata <= DATA_W'(reload);
				ADDR_STATUS: rdata <= DATA_W'(status);
				ADDR_ENABLE: rdata <= DATA_W'(enable);
				ADDR_PRESCALE: rdata <= DATA_W'(prescale);
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end
endmodule

// >>> dv/mmt_timer_sva.sv
// checker for the multimode timer port behaviour
`timescale 1ns/1ns
module mmt_timer_sva #(
	parameter int unsigned DATA_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [mmt_pkg::ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic irq,
	input wire logic first_timer_output_pin,
	input wire logic auxiliary_timer_io_pin_in,
	input wire logic auxiliary_timer_io_pin_out,
	input wire logic auxiliary_timer_io_pin_oe
);
	import mmt_pkg::*;
	logic [4:0] mode_q;
	logic entry;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// last written mode, so a mode entry can be judged from the ports alone
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= 5'h01;
		end else if (wr && addr == ADDR_CTRL) begin
			mode_q <= wdata[5:1];
		end
	end
	assign entry = (mode_q == MMT_TIMER || mode_q == MMT_EVENT) && (wdata[5:1] == MMT_ONESHOT || wdata[5:1] == MMT_PWM);
	a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
		else $error("read data not zero outside read answer");
	a_halted_write: assert property (wr && addr == ADDR_COUNT ##1 rd && addr == ADDR_RELOAD |=> rdata == $past(wdata, 2))
		else $error("reload readback differs from written value");
	a_stop_low: assert property (wr && addr == ADDR_CTRL && !wdata[0] && auxiliary_timer_io_pin_oe |-> ##[1:2] !first_timer_output_pin)
		else $error("output not low after stop");
	a_pin_mirror: assert property (auxiliary_timer_io_pin_out == first_timer_output_pin)
		else $error("pin copies disagree");
	a_pin_enabled: assert property (first_timer_output_pin |-> auxiliary_timer_io_pin_oe)
		else $error("output high without enable");
	a_mode_req: assert property (wr && addr == ADDR_CTRL && entry ##1 rd && addr == ADDR_STATUS |=> rdata[STAT_REQ])
		else $error("mode entry did not set request");
	a_mask_irq: assert property (wr && addr == ADDR_ENABLE && wdata == '0 |-> ##2 !irq)
		else $error("irq high with all sources masked");
	a_empty_read: assert property (rd && (addr == ADDR_CLEAR || addr == 5'h1C) |=> rdata == '0)
		else $error("clear or unmapped read not zero");
	a_status_high: assert property (rd && addr == ADDR_STATUS |=> rdata[DATA_W-1:STAT_W] == '0)
		else $error("status upper bits not zero");
	a_reset_quiet: assert property ($rose(rst_b) |-> !irq && !first_timer_output_pin)
		else $error("outputs active right after reset");
	c_irq: cover property ($rose(irq));
	c_pin: cover property ($rose(first_timer_output_pin));
	c_entry: cover property (wr && addr == ADDR_CTRL && entry);
endmodule
bind mmt_timer mmt_timer_sva #(.DATA_W(DATA_W)) chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .first_timer_output_pin(first_timer_output_pin),
	.auxiliary_timer_io_pin_in(auxiliary_timer_io_pin_in), .auxiliary_timer_io_pin_out(auxiliary_timer_io_pin_out),
	.auxiliary_timer_io_pin_oe(auxiliary_timer_io_pin_oe));

// >>> dv/mmt_ext_src.sv
// external event source: square wave on the timer input while run is high
`timescale 1ns/1ns
module mmt_ext_src #(
	parameter int unsigned HALF = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	output logic pin
);
	int unsigned cnt;
	// parked low between bursts so the rising edges counted are exact
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b || !run) begin
			cnt <= 0;
			pin <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			pin <= !pin;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> dv/mmt_timer_tb.sv
// self-checking bench for the multimode timer
`timescale 1ns/1ns
module mmt_timer_tb;
	import mmt_pkg::*;
	typedef struct {
		logic [15:0] prev;
		logic [15:0] next;
		logic [15:0] exp;
	} mmt_row_t;
	logic clk, rst_b, wr, rd, run, irq, pin, aux_in, aux_out, aux_oe;
	logic [ADDR_W-1:0] addr;
	logic [15:0] wdata, rdata;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	mmt_row_t rows [5] = '{'{16'h0002, 16'h0008, 16'h0001}, '{16'h0002, 16'h0010, 16'h0001},
		'{16'h0004, 16'h0008, 16'h0001}, '{16'h0004, 16'h0010, 16'h0001}, '{16'h0002, 16'h0004, 16'h0000}};
	mmt_timer dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq(irq), .first_timer_output_pin(pin), .auxiliary_timer_io_pin_in(aux_in),
		.auxiliary_timer_io_pin_out(aux_out), .auxiliary_timer_io_pin_oe(aux_oe));
	mmt_ext_src src (.clk(clk), .rst_b(rst_b), .run(run), .pin(aux_in));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// strobe is left high so writes can follow each other; idle lowers it
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	// read data stand only in the cycle after the strobe; look mid-cycle, resume on the edge
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
		@(posedge clk);
	endtask
	initial begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		run = 1'b0;
		addr = '0;
		wdata = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rchk(ADDR_CTRL, 16'h0002);
		rchk(ADDR_STATUS, 16'h0000);
		rchk(5'h1C, 16'h0000);
		foreach (rows[i]) begin
			wreg(ADDR_CTRL, rows[i].prev);
			wreg(ADDR_CLEAR, 16'h0003);
			wreg(ADDR_CTRL, rows[i].next);
			rchk(ADDR_STATUS, rows[i].exp);
		end
		wreg(ADDR_CTRL, 16'h0002);
		wreg(ADDR_COUNT, 16'h1234);
		rchk(ADDR_RELOAD, 16'h1234);
		rchk(ADDR_COUNT, 16'h1234);
		wreg(ADDR_CTRL, 16'h0003);
		idle(2);
		rchk(ADDR_COUNT, 16'h1232);
		wreg(ADDR_CTRL, 16'h0002);
		// reload of zero makes every tick a reload instant
		wreg(ADDR_COUNT, 16'h0000);
		wreg(ADDR_PRESCALE, 16'h0000);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_ENABLE, 16'h0001);
		wreg(ADDR_CTRL, 16'h0003);
		idle(3);
		rchk(ADDR_COUNT, 16'hFFFF);
		chk({15'h0, irq}, 16'h0001);
		wreg(ADDR_ENABLE, 16'h0000);
		idle(3);
		chk({15'h0, irq}, 16'h0000);
		wreg(ADDR_CTRL, 16'h0002);
		wreg(ADDR_CLEAR, 16'h0001);
		wreg(ADDR_ENABLE, 16'h0001);
		idle(3);
		chk({15'h0, irq}, 16'h0000);
		wreg(ADDR_CTRL, 16'h0008);
		wreg(ADDR_COUNT, 16'h0100);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_CTRL, 16'h0009);
		idle(4);
		chk({15'h0, pin}, 16'h0001);
		chk({14'h0, aux_oe, aux_out}, 16'h0003);
		wreg(ADDR_CTRL, 16'h0008);
		idle(3);
		chk({15'h0, pin}, 16'h0000);
		chk({14'h0, aux_oe, aux_out}, 16'h0002);
		rchk(ADDR_STATUS, 16'h0001);
		rchk(ADDR_COUNT, 16'h0100);
		wreg(ADDR_CTRL, 16'h0010);
		wreg(ADDR_COUNT, 16'h0004);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_CTRL, 16'h0011);
		idle(3);
		chk({15'h0, pin}, 16'h0001);
		wreg(ADDR_CTRL, 16'h0010);
		idle(3);
		chk({15'h0, pin}, 16'h0000);
		rchk(ADDR_STATUS, 16'h0001);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_CTRL, 16'h0011);
		idle(12);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_CTRL, 16'h0010);
		idle(3);
		chk({15'h0, pin}, 16'h0000);
		rchk(ADDR_STATUS, 16'h0000);
		wreg(ADDR_CTRL, 16'h0004);
		wreg(ADDR_COUNT, 16'h0002);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_CTRL, 16'h0005);
		run <= 1'b1;
		idle(10);
		rchk(ADDR_COUNT, 16'hFFFF);
		run <= 1'b0;
		idle(4);
		rchk(ADDR_STATUS, 16'h0001);
		rchk(ADDR_COUNT, 16'h0002);
		wreg(ADDR_CTRL, 16'h0004);
		wreg(ADDR_COUNT, 16'hFFFF);
		// up count, free run: the wrap reads zero and leaves zero, not the reload value
		wreg(ADDR_CTRL, 16'h00C5);
		run <= 1'b1;
		idle(2);
		rchk(ADDR_COUNT, 16'h0000);
		run <= 1'b0;
		idle(2);
		rchk(ADDR_COUNT, 16'h0000);
		wreg(ADDR_CTRL, 16'h0084);
		wreg(ADDR_COUNT, 16'h0002);
		rchk(ADDR_COUNT, 16'h0002);
		wreg(ADDR_CTRL, 16'h0020);
		wreg(ADDR_CLEAR, 16'h0003);
		wreg(ADDR_CTRL, 16'h0021);
		run <= 1'b1;
		idle(3);
		run <= 1'b0;
		idle(4);
		rchk(ADDR_STATUS, 16'h0000);
		wreg(ADDR_CTRL, 16'h0121);
		rchk(ADDR_STATUS, 16'h0001);
		end_of_test();
	end
endmodule
